// ### hw/fsc_station_config.sv
// Fieldbus station configuration, word limits and diagnostic serial port
`timescale 1ns/1ps
`include "fsc_params.svh"
`default_nettype none

module fsc_station_config #(
    parameter int FLASH_CYC = `FSC_FLASH_CYC,
    parameter int INIT_CYC  = `FSC_INIT_CYC
) (
    input  wire logic            i_clock,
    input  wire logic            i_nrst,
    input  wire logic [7:0]      i_awaddr,
    input  wire logic            i_awvalid,
    output logic                 o_awready,
    input  wire logic [31:0]     i_wdata,
    input  wire logic [3:0]      i_wstrb,
    input  wire logic            i_wvalid,
    output logic                 o_wready,
    output logic [1:0]           o_bresp,
    output logic                 o_bvalid,
    input  wire logic            i_bready,
    input  wire logic [7:0]      i_araddr,
    input  wire logic            i_arvalid,
    output logic                 o_arready,
    output logic [31:0]          o_rdata,
    output logic [1:0]           o_rresp,
    output logic                 o_rvalid,
    input  wire logic            i_rready,
    input  wire fsc_pkg::fsc_sw_t i_switches,
    input  wire logic            i_device_fault,
    input  wire logic            i_uart_rx,
    output logic                 o_uart_tx,
    output logic                 o_power_green,
    output logic                 o_power_red,
    output logic                 o_run_green,
    output logic                 o_link_err_red,
    output logic                 o_irq,
    output logic [7:0]           o_station_first,
    output logic [7:0]           o_station_last,
    output logic [7:0]           o_word_grant,
    output logic                 o_word_dual,
    output logic                 o_bit_dual,
    output logic                 o_default_read
);

    localparam int BIT_CYC = `FSC_BIT_CYC;
    localparam int HALF_CYC = BIT_CYC / 2;

    // Counters below are 32 bits; tiny values would break the flash and start-up hold-off
    generate
        if (FLASH_CYC < 2 || INIT_CYC < 1) begin : g_bad_param
            $error("fsc_station_config: FLASH_CYC >= 2, INIT_CYC >= 1");
        end
    endgenerate

    fsc_pkg::fsc_state_t state_r;
    fsc_pkg::fsc_cfg_t   cfg_r;
    fsc_pkg::fsc_sw_t    latched_r;
    logic [31:0] init_cnt_r;
    logic        sw_changed_r;
    logic        mismatch;
    logic        init_done;
    logic        cfg_ok;
    logic [31:0] flash_cnt_r;
    logic        flash_r;
    logic [`FSC_EV_W-1:0] status_r;
    logic [`FSC_EV_W-1:0] enable_r;
    logic [`FSC_EV_W-1:0] events;
    logic [`FSC_EV_W-1:0] clear_mask;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic        wr_hit;
    logic [10:0] xfer_r;
    logic [7:0]  grant_r;
    logic [7:0]  lim_both;
    logic [7:0]  lim_ch1;
    logic [7:0]  lim;
    logic [10:0] xfer_nxt;
    logic        xfer_wr;
    logic [9:0]  tx_shift_r;
    logic [3:0]  tx_bits_r;
    logic [31:0] tx_div_r;
    logic        tx_busy;
    logic        tx_done;
    logic        rx_prev_r;
    logic        rx_busy_r;
    logic [3:0]  rx_bits_r;
    logic [31:0] rx_div_r;
    logic [8:0]  rx_shift_r;
    logic [7:0]  rx_data_r;
    logic        rx_byte;
    logic        rx_err;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Start-up: hold off INIT_CYC cycles, latch once, then run until reset
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r    <= fsc_pkg::ST_WAIT;
            init_cnt_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                fsc_pkg::ST_WAIT: begin
                    init_cnt_r <= init_cnt_r + 32'h0000_0001;
                    if (init_cnt_r >= 32'(INIT_CYC - 1)) begin
                        state_r <= fsc_pkg::ST_LATCH;
                    end
                end
                fsc_pkg::ST_LATCH: state_r <= fsc_pkg::ST_RUN;
                fsc_pkg::ST_RUN:   state_r <= fsc_pkg::ST_RUN;
                default:           state_r <= fsc_pkg::ST_WAIT;
            endcase
        end
    end

    // Switch capture is clocked, so reset itself only loads constants
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            latched_r <= '0;
            cfg_r     <= '0;
        end else if (state_r == fsc_pkg::ST_LATCH) begin
            latched_r <= i_switches;
            cfg_r.station <= 8'({4'h0, i_switches.tens} * 8'h0A)
                           + {4'h0, i_switches.units};
            cfg_r.station_ok <= (i_switches.tens <= `FSC_DIGIT_MAX)
                && (i_switches.units <= `FSC_DIGIT_MAX)
                && (8'({4'h0, i_switches.tens} * 8'h0A)
                    + {4'h0, i_switches.units} >= `FSC_STATION_MIN)
                && (8'({4'h0, i_switches.tens} * 8'h0A)
                    + {4'h0, i_switches.units} <= `FSC_STATION_MAX);
            cfg_r.rate    <= i_switches.rate[2:0];
            cfg_r.rate_ok <= (i_switches.rate <= `FSC_RATE_MAX);
            case (i_switches.ext)
                4'h1, 4'h2, 4'h4, 4'h8: begin
                    cfg_r.v2   <= 1'b1;
                    cfg_r.ways <= i_switches.ext;
                end
                default: begin
                    cfg_r.v2   <= 1'b0;
                    cfg_r.ways <= 4'h1;
                end
            endcase
        end
    end

    assign init_done = (state_r == fsc_pkg::ST_RUN);
    assign cfg_ok    = cfg_r.station_ok && cfg_r.rate_ok;

    assign mismatch = init_done
        && ({i_switches.tens, i_switches.units, i_switches.rate}
            != {latched_r.tens, latched_r.units, latched_r.rate});

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_changed_r <= 1'b0;
        end else if (mismatch) begin
            sw_changed_r <= 1'b1;
        end
    end

    // Free-running 0.4 s phase for the error flash
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= 1'b0;
        end else if (flash_cnt_r >= 32'(FLASH_CYC - 1)) begin
            flash_cnt_r <= 32'h0000_0000;
            flash_r     <= ~flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
        end
    end

    // Indicators are registered so they never glitch
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_power_green  <= 1'b0;
            o_power_red    <= 1'b1;
            o_run_green    <= 1'b0;
            o_link_err_red <= 1'b0;
        end else begin
            o_power_green <= init_done && !i_device_fault;
            o_power_red   <= !(init_done && !i_device_fault);
            o_run_green <= init_done && cfg_ok;
            if (init_done && !cfg_ok) begin
                o_link_err_red <= 1'b1;
            end else if (init_done && sw_changed_r) begin
                o_link_err_red <= flash_r;
            end else begin
                o_link_err_red <= 1'b0;
            end
        end
    end

    // Station slots follow the latched number; bit areas always carry both channels
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_station_first <= 8'h00;
            o_station_last  <= 8'h00;
            o_bit_dual      <= 1'b0;
        end else begin
            o_station_first <= cfg_r.station;
            o_station_last  <= cfg_r.station + `FSC_STATIONS - 8'h01;
            o_bit_dual <= 1'b1;
        end
    end

    // AXI4-Lite write: address and data accepted in either order
    assign o_awready = !aw_held_r && !o_bvalid;
    assign o_wready  = !w_held_r && !o_bvalid;
    assign wr_go     = aw_held_r && w_held_r && !o_bvalid;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            o_bvalid  <= 1'b0;
            o_bresp   <= `FSC_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= i_wdata;
                wstrb_r  <= i_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_hit ? `FSC_RESP_OKAY : `FSC_RESP_DECERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    assign wr_hit = (awaddr_r == `FSC_REG_CLEAR)
        || (awaddr_r == `FSC_REG_ENABLE) || (awaddr_r == `FSC_REG_XFER)
        || (awaddr_r == `FSC_REG_TXDATA);

    always_comb begin
        xfer_nxt = xfer_r;
        if (wstrb_r[0]) begin
            xfer_nxt[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            xfer_nxt[10:8] = wdata_r[10:8];
        end
    end
    assign xfer_wr = wr_go && (awaddr_r == `FSC_REG_XFER)
        && (wstrb_r[1:0] != 2'b00);

    assign lim_both = {2'b00, cfg_r.ways, 2'b00} - 8'h01;
    assign lim_ch1  = {1'b0, cfg_r.ways, 3'b000} - 8'h01;
    assign lim = xfer_nxt[`FSC_XF_CH1ONLY] ? lim_ch1 : lim_both;

    // Granted count may be smaller than asked, never larger
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            xfer_r         <= 11'h000;
            grant_r        <= 8'h00;
            o_default_read <= 1'b0;
        end else if (xfer_wr) begin
            xfer_r  <= xfer_nxt;
            grant_r <= (xfer_nxt[7:0] > lim) ? lim : xfer_nxt[7:0];
            o_default_read <= xfer_nxt[`FSC_XF_FAM_DEF]
                && (xfer_nxt[7:0] == 8'h00);
        end
    end
    assign o_word_grant = grant_r;
    assign o_word_dual  = !xfer_r[`FSC_XF_CH1ONLY];

    // Event sources; set beats clear in the same cycle
    always_comb begin
        events = '0;
        events[`FSC_EV_SWCHG] = mismatch && !sw_changed_r;
        events[`FSC_EV_CLIP]  = xfer_wr && (xfer_nxt[7:0] > lim);
        events[`FSC_EV_BADBLK] = xfer_wr && xfer_nxt[`FSC_XF_FAM_BLK]
            && (xfer_nxt[0] || (xfer_nxt[7:0] > `FSC_BLK_MAX));
        events[`FSC_EV_RXBYTE] = rx_byte;
        events[`FSC_EV_RXERR]  = rx_err;
        events[`FSC_EV_TXDONE] = tx_done;
    end
    assign clear_mask = (wr_go && awaddr_r == `FSC_REG_CLEAR && wstrb_r[0])
        ? wdata_r[`FSC_EV_W-1:0] : '0;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            status_r <= '0;
            enable_r <= `FSC_ENABLE_RST;
        end else begin
            status_r <= (status_r & ~clear_mask) | events;
            if (wr_go && awaddr_r == `FSC_REG_ENABLE && wstrb_r[0]) begin
                enable_r <= wdata_r[`FSC_EV_W-1:0];
            end
        end
    end
    assign o_irq = |(status_r & enable_r);

    assign tx_busy = (tx_bits_r != 4'h0);
    assign tx_done = tx_busy && (tx_bits_r == 4'h1)
        && (tx_div_r >= 32'(BIT_CYC - 1));

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_shift_r <= 10'h3FF;
            tx_bits_r  <= 4'h0;
            tx_div_r   <= 32'h0000_0000;
        end else if (!tx_busy) begin
            // A write while busy is dropped; software polls the busy bit
            if (wr_go && awaddr_r == `FSC_REG_TXDATA && wstrb_r[0]) begin
                tx_shift_r <= {1'b1, wdata_r[7:0], 1'b0};
                tx_bits_r  <= 4'hA;
                tx_div_r   <= 32'h0000_0000;
            end
        end else if (tx_div_r >= 32'(BIT_CYC - 1)) begin
            tx_div_r   <= 32'h0000_0000;
            tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            tx_bits_r  <= tx_bits_r - 4'h1;
        end else begin
            tx_div_r <= tx_div_r + 32'h0000_0001;
        end
    end
    assign o_uart_tx = tx_shift_r[0];

    // receiver samples mid-bit after start edge
    assign rx_byte = rx_busy_r && (rx_bits_r == 4'h0)
        && (rx_div_r == 32'h0000_0000) && i_uart_rx;
    assign rx_err  = rx_busy_r && (rx_bits_r == 4'h0)
        && (rx_div_r == 32'h0000_0000) && !i_uart_rx;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_prev_r  <= 1'b1;
            rx_busy_r  <= 1'b0;
            rx_bits_r  <= 4'h0;
            rx_div_r   <= 32'h0000_0000;
            rx_shift_r <= 9'h000;
            rx_data_r  <= 8'h00;
        end else begin
            rx_prev_r <= i_uart_rx;
            if (!rx_busy_r) begin
                if (rx_prev_r && !i_uart_rx) begin
                    rx_busy_r <= 1'b1;
                    rx_bits_r <= 4'h8;
                    rx_div_r  <= 32'(HALF_CYC + BIT_CYC - 1);
                end
            end else if (rx_div_r != 32'h0000_0000) begin
                rx_div_r <= rx_div_r - 32'h0000_0001;
            end else if (rx_bits_r != 4'h0) begin
                rx_shift_r <= {i_uart_rx, rx_shift_r[8:1]};
                rx_bits_r  <= rx_bits_r - 4'h1;
                rx_div_r   <= 32'(BIT_CYC - 1);
            end else begin
                // Stop bit sampled; byte kept only if framing holds
                rx_busy_r <= 1'b0;
                if (i_uart_rx) begin
                    rx_data_r <= rx_shift_r[8:1];
                end
            end
        end
    end

    // Read data selection
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (i_araddr)
            `FSC_REG_CONFIG: rd_word = {12'h000, init_done, cfg_r.rate_ok,
                cfg_r.station_ok, cfg_r.v2, cfg_r.ways, 1'b0, cfg_r.rate,
                cfg_r.station};
            `FSC_REG_LIVE:   rd_word = {16'h0000, i_switches};
            `FSC_REG_STATUS: rd_word = {26'h000_0000, status_r};
            `FSC_REG_CLEAR:  rd_word = 32'h0000_0000;
            `FSC_REG_ENABLE: rd_word = {26'h000_0000, enable_r};
            `FSC_REG_XFER:   rd_word = {8'h00, grant_r, 5'h00, xfer_r};
            `FSC_REG_TXDATA: rd_word = {23'h00_0000, tx_busy, 8'h00};
            `FSC_REG_RXDATA: rd_word = {24'h00_0000, rx_data_r};
            default:         rd_hit  = 1'b0;
        endcase
    end

    // AXI4-Lite read: one cycle from address to data
    assign o_arready = !o_rvalid;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= 32'h0000_0000;
            o_rresp  <= `FSC_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata  <= rd_word;
            o_rresp  <= rd_hit ? `FSC_RESP_OKAY : `FSC_RESP_DECERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

endmodule // fsc_station_config

`default_nettype wire

// ### hw/fsc_params.svh
// Offsets, field positions, reset values and timing counts of the station block
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

// Register byte offsets
`define FSC_REG_CONFIG    8'h00
`define FSC_REG_LIVE      8'h04
`define FSC_REG_STATUS    8'h08
`define FSC_REG_CLEAR     8'h0C
`define FSC_REG_ENABLE    8'h10
`define FSC_REG_XFER      8'h14
`define FSC_REG_TXDATA    8'h18
`define FSC_REG_RXDATA    8'h1C

// Status / enable bit positions
`define FSC_EV_SWCHG      0
`define FSC_EV_CLIP       1
`define FSC_EV_BADBLK     2
`define FSC_EV_RXBYTE     3
`define FSC_EV_RXERR      4
`define FSC_EV_TXDONE     5
`define FSC_EV_W          6

// Transfer request fields
`define FSC_XF_CH1ONLY    8
`define FSC_XF_FAM_DEF    9
`define FSC_XF_FAM_BLK    10

// Reset values and bus response codes
`define FSC_ENABLE_RST    6'h00
`define FSC_RESP_OKAY     2'h0
`define FSC_RESP_DECERR   2'h3

// Switch limits and fixed figures
`define FSC_STATION_MIN   8'h01
`define FSC_STATION_MAX   8'h40
`define FSC_DIGIT_MAX     4'h9
`define FSC_RATE_MAX      4'h4
`define FSC_STATIONS      8'h04
`define FSC_BLK_MAX       8'h07

// Timing: clock, serial rate, flash interval and start-up hold-off
`define FSC_CLK_HZ        125000000
`define FSC_BAUD          38400
`define FSC_BIT_CYC       (`FSC_CLK_HZ / `FSC_BAUD)
`define FSC_FLASH_MS      400
`define FSC_FLASH_CYC     ((`FSC_CLK_HZ / 1000) * `FSC_FLASH_MS)
`define FSC_INIT_CYC      16

`endif

// ### hw/fsc_pkg.sv
// Types shared by the station configuration block
package fsc_pkg;

    // Raw rotary switch inputs, one nibble per switch
    typedef struct packed {
        logic [3:0] tens;
        logic [3:0] units;
        logic [3:0] rate;
        logic [3:0] ext;
    } fsc_sw_t;

    // Start-up configuration as latched and decoded
    typedef struct packed {
        logic [7:0] station;
        logic [2:0] rate;
        logic [3:0] ways;
        logic       v2;
        logic       station_ok;
        logic       rate_ok;
    } fsc_cfg_t;

    // Start-up sequence
    typedef enum logic [2:0] {
        ST_WAIT  = 3'b001,
        ST_LATCH = 3'b010,
        ST_RUN   = 3'b100
    } fsc_state_t;

endpackage

// ### test/fsc_chk.sv
// Port-level checks for the station configuration block
`timescale 1ns/1ps
`default_nettype none

module fsc_chk (
    input wire logic       i_clock,
    input wire logic       i_nrst,
    input wire logic       i_arvalid,
    input wire logic       i_rready,
    input wire logic       i_bready,
    input wire logic       i_device_fault,
    input wire logic       o_arready,
    input wire logic       o_rvalid,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic       o_bvalid,
    input wire logic [1:0] o_bresp,
    input wire logic       o_run_green,
    input wire logic [7:0] o_station_first,
    input wire logic [7:0] o_station_last,
    input wire logic       o_bit_dual,
    input wire logic [7:0] o_word_grant,
    input wire logic       o_power_green,
    input wire logic       o_power_red
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // Bus handshakes: one read in flight, answers stand until taken
    a_ar_block: assert property (o_rvalid |-> !o_arready)
        else $error("read address open while answer stands");
    a_read_next: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read answer not one cycle after address");
    a_read_hold: assert property (o_rvalid && !i_rready |=>
        o_rvalid && $stable(o_rdata) && $stable(o_rresp))
        else $error("read answer dropped or changed early");
    a_resp_hold: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp))
        else $error("write response dropped or changed early");
    // Station slots while running, word grant limit and fault indicator
    a_slot_span: assert property (o_run_green |->
        o_station_last == o_station_first + 8'h03)
        else $error("station span is not four slots");
    a_slot_range: assert property (o_run_green |->
        o_station_first inside {[8'h01:8'h40]})
        else $error("running with station out of range");
    a_bit_dual: assert property (o_run_green |-> o_bit_dual)
        else $error("bit areas not carrying both channels");
    a_grant_max: assert property (o_word_grant <= 8'h3F)
        else $error("word grant above largest limit");
    a_fault_red: assert property (i_device_fault |=>
        o_power_red && !o_power_green)
        else $error("fault not shown on power indicator");

    // Main scenarios reached
    cover property (o_bvalid && i_bready);
    cover property (o_rvalid && o_rresp == 2'h3);
    cover property (i_device_fault && o_run_green);
endmodule // fsc_chk

bind fsc_station_config fsc_chk fsc_chk_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_arvalid(i_arvalid),
    .i_rready(i_rready), .i_bready(i_bready),
    .i_device_fault(i_device_fault), .o_arready(o_arready),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_run_green(o_run_green),
    .o_station_first(o_station_first), .o_station_last(o_station_last),
    .o_bit_dual(o_bit_dual), .o_word_grant(o_word_grant),
    .o_power_green(o_power_green), .o_power_red(o_power_red));

`default_nettype wire

// ### test/fsc_host.sv
// Serial diagnostic host model facing the block's serial port
`timescale 1ns/1ps
`default_nettype none

module fsc_host #(
    parameter int BIT_CYC = 3255
) (
    input  wire logic i_clock,
    input  wire logic i_line,
    output var logic  o_line
);
    // Line idles high between frames
    initial o_line = 1'b1;

    // start, eight data LSB first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= f[i];
            repeat (BIT_CYC) @(posedge i_clock);
        end
    endtask

    // sample each bit mid-cell, then the stop bit
    task automatic recv(output logic [7:0] b, output logic stp);
        @(negedge i_line);
        repeat (BIT_CYC + BIT_CYC / 2) @(posedge i_clock);
        for (int i = 0; i < 8; i++) begin
            b[i] = i_line;
            repeat (BIT_CYC) @(posedge i_clock);
        end
        stp = i_line;
    endtask
endmodule // fsc_host

`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the station configuration block
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"

module tb;
    localparam int FL = 8;
    localparam int IN = 4;
    logic             clk, nrst, awv, wv, bry, arv, rry, flt, rx, tx;
    logic             awr, wrd, bv, arr, rv, pg, pr, rg, er, irq;
    logic             wdl, bd, dr;
    logic [7:0]       awa, ara, sf, sl, gr;
    logic [31:0]      wd, rdata;
    logic [1:0]       bresp, rresp;
    fsc_pkg::fsc_sw_t sw;
    logic [3:0]       xs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};
    int               error_cnt, tests_run;

    fsc_station_config #(.FLASH_CYC(FL), .INIT_CYC(IN))
        fsc_station_config_inst (
        .i_clock(clk), .i_nrst(nrst), .i_awaddr(awa), .i_awvalid(awv),
        .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv),
        .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv), .i_bready(bry),
        .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rry), .i_switches(sw),
        .i_device_fault(flt), .i_uart_rx(rx), .o_uart_tx(tx),
        .o_power_green(pg), .o_power_red(pr), .o_run_green(rg),
        .o_link_err_red(er), .o_irq(irq), .o_station_first(sf),
        .o_station_last(sl), .o_word_grant(gr), .o_word_dual(wdl),
        .o_bit_dual(bd), .o_default_read(dr));

    fsc_host #(.BIT_CYC(`FSC_BIT_CYC)) host (.i_clock(clk), .i_line(tx),
        .o_line(rx));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (e !== g) begin
            $display("unexpected %s: expected %0h, seen %0h", n, e, g);
            error_cnt++;
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && awr === 1'b1) begin pa = 1'b0; awv <= 1'b0; end
            if (pw && wrd === 1'b1) begin pw = 1'b0; wv <= 1'b0; end
        end
        do @(posedge clk); while (bv !== 1'b1);
        bry <= 1'b1;
        @(posedge clk);
        r = bresp;
        bry <= 1'b0;
    endtask

    // Read: ready raised late so the answer is seen standing
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        ara <= a; arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rry <= 1'b1;
        @(posedge clk);
        d = rdata; r = rresp;
        rry <= 1'b0;
    endtask

    task automatic boot(input fsc_pkg::fsc_sw_t s);
        nrst <= 1'b0; sw <= s;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (IN + 4) @(posedge clk);
    endtask

    function automatic logic [7:0] ways(input logic [3:0] x);
        return (x inside {4'h1, 4'h2, 4'h4, 4'h8}) ? {4'h0, x} : 8'h01;
    endfunction

    function automatic logic [7:0] grant(input logic [3:0] x,
                                         input logic c1, input logic [7:0] n);
        logic [7:0] l;
        l = (c1 ? 8'h08 : 8'h04) * ways(x) - 8'h01;
        return (n < l) ? n : l;
    endfunction

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: seven extension codes, then faults, bus, serial
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  n, c, b, q;
        logic [3:0]  rt;
        logic        s, p;
        int          t;
        awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0;
        rry = 1'b0; flt = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h0;
        void'($urandom(16768));
        for (int k = 0; k < 7; k++) begin
            n = 8'($urandom_range(32'h40, 32'h1));
            rt = 4'($urandom_range(32'h4, 32'h0));
            boot({4'(n / 8'h0A), 4'(n % 8'h0A), rt, xs[k]});
            chk("first slot", n, sf);
            chk("last slot", n + 8'h03, sl);
            chk("run", 1'b1, rg);
            rd(`FSC_REG_CONFIG, d, r);
            chk("config", {ways(xs[k]) != 8'h01 || xs[k] == 4'h1,
                4'(ways(xs[k])), rt[2:0]}, {d[16:12], d[10:8]});
            for (int c1 = 0; c1 < 2; c1++) begin
                c = k[0] ? 8'hFF : 8'($urandom);
                wr(`FSC_REG_XFER, {23'h0, c1[0], c}, r);
                @(posedge clk);
                chk("grant", grant(xs[k], c1[0], c), gr);
                chk("word dual", !c1[0], wdl);
            end
            chk("bit dual", 1'b1, bd);
        end
        flt <= 1'b1;
        repeat (2) @(posedge clk);
        chk("power red", 1'b1, pr);
        flt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("power green", 1'b1, pg);
        wr(`FSC_REG_XFER, 32'h0000_0200, r);
        @(posedge clk);
        chk("default read", 1'b1, dr);
        wr(`FSC_REG_XFER, 32'h0000_0406, r);
        rd(`FSC_REG_STATUS, d, r);
        chk("block even", 1'b0, d[2]);
        wr(`FSC_REG_XFER, 32'h0000_0408, r);
        rd(`FSC_REG_STATUS, d, r);
        chk("block over", 1'b1, d[2]);
        rd(8'h20, d, r);
        chk("unmapped resp", `FSC_RESP_DECERR, r);
        chk("unmapped data", 32'h0, d);
        wr(`FSC_REG_CONFIG, 32'hFFFF_FFFF, r);
        chk("read-only resp", `FSC_RESP_DECERR, r);
        wr(`FSC_REG_ENABLE, 32'h1, r);
        sw <= sw ^ 16'h0110;
        t = 0;
        p = er;
        repeat (5 * FL) begin
            @(posedge clk);
            if (er !== p) t++;
            p = er;
        end
        chk("flashing", 1'b1, t >= 4);
        chk("station kept", n, sf);
        chk("irq set", 1'b1, irq);
        wr(`FSC_REG_ENABLE, 32'h0, r);
        @(posedge clk);
        chk("irq masked", 1'b0, irq);
        wr(`FSC_REG_ENABLE, 32'h1, r);
        wr(`FSC_REG_CLEAR, 32'h1, r);
        @(posedge clk);
        chk("irq cleared", 1'b0, irq);
        boot({4'h1, 4'h0, 4'h5, 4'h0});
        chk("run bad rate", 1'b0, rg);
        repeat (FL + 1) @(posedge clk);
        chk("err steady", 1'b1, er);
        boot({4'h1, 4'h2, 4'h3, 4'h0});
        q = 8'($urandom);
        fork
            host.send(q);
            wr(`FSC_REG_TXDATA, 32'h0000_00A5, r);
            host.recv(b, s);
        join
        chk("tx byte", 8'hA5, b);
        chk("tx stop", 1'b1, s);
        rd(`FSC_REG_RXDATA, d, r);
        chk("rx byte", q, d[7:0]);
        finish_test();
    end

    // Watchdog sized well past the two serial frames
    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule // tb

`default_nettype wire
